// ### rtl/lcd_col_pkg.sv
// Shared constants for the LCD column driver core
package lcd_col_pkg;

  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int PAGE_W     = 3;                    // Page part of the RAM address
  localparam int COL_W      = 6;                    // Column part of the RAM address
  localparam int ADDR_W     = PAGE_W + COL_W;       // 9-bit RAM address
  localparam int LINE_W     = 6;                    // Start line and refresh line counter
  localparam int DATA_W     = 8;                    // Host data bus width
  localparam int SEG_N      = 64;                   // Segment outputs
  localparam int RAM_DEPTH  = 512;                  // Bytes of display RAM
  localparam int LEVEL_W    = 2;                    // Drive level code per segment

  // ************************************************************
  // Instruction codes (bus written with data select low)
  // ************************************************************
  localparam logic [6:0] ONOFF_CODE = 7'h1f;        // Upper seven bits of display on/off
  localparam logic [1:0] START_CODE = 2'h3;         // Top two bits of start line
  localparam logic [4:0] PAGE_CODE  = 5'h17;        // Upper five bits of set page
  localparam logic [1:0] COL_CODE   = 2'h1;         // Top two bits of set column

  // ************************************************************
  // Status word bit positions
  // ************************************************************
  localparam int STAT_BUSY_BIT  = 7;
  localparam int STAT_OFF_BIT   = 5;
  localparam int STAT_RESET_BIT = 4;

  // ************************************************************
  // Drive level codes
  // ************************************************************
  localparam logic [1:0] LEVEL_ONE   = 2'h0;        // Phase high, dot on
  localparam logic [1:0] LEVEL_TWO   = 2'h1;        // Phase low, dot on
  localparam logic [1:0] LEVEL_THREE = 2'h2;        // Phase high, dot off
  localparam logic [1:0] LEVEL_FOUR  = 2'h3;        // Phase low, dot off

  // ************************************************************
  // Reset values and timing counts
  // ************************************************************
  localparam logic [5:0] START_LINE_RST = 6'h00;    // Display from line 0
  localparam logic       DISPLAY_ON_RST = 1'b0;     // Display off
  localparam int         BUSY_PHASES    = 2;        // Phase-one rises that end busy
  localparam int         RESET_CYCLES   = 16;       // Init window after reset release

endpackage

// ### rtl/lcd_column_driver_core.sv
// LCD column driver core: host bus, display RAM, refresh addressing, segment drive
`timescale 1ns/1ps

module lcd_column_driver_core (
  // System
  input  wire logic                                            clk_sys,
  input  wire logic                                            rst_n,
  // Host bus
  input  wire logic                                            chip_select_a_n,
  input  wire logic                                            chip_select_b_n,
  input  wire logic                                            chip_select_c,
  input  wire logic                                            bus_strobe,
  input  wire logic                                            read_not_write,
  input  wire logic                                            data_not_instr,
  input  wire logic [lcd_col_pkg::DATA_W-1:0]                  bus_in,
  output logic      [lcd_col_pkg::DATA_W-1:0]                  bus_out_q,
  output logic                                                 bus_oe_n_q,
  // Static strap
  input  wire logic                                            order_select,
  // Timing from the row driver
  input  wire logic                                            phase_one,
  input  wire logic                                            frame_sync,
  input  wire logic                                            line_latch_clock,
  input  wire logic                                            ac_phase,
  // Segment drive
  output logic      [lcd_col_pkg::SEG_N*lcd_col_pkg::LEVEL_W-1:0] segment_outputs_q
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [lcd_col_pkg::DATA_W-1:0]   ram_q [lcd_col_pkg::RAM_DEPTH];
  logic [lcd_col_pkg::LINE_W-1:0]   start_line_q;
  logic [lcd_col_pkg::PAGE_W-1:0]   page_select_q;
  logic [lcd_col_pkg::COL_W-1:0]    column_counter_q;
  logic [lcd_col_pkg::LINE_W-1:0]   line_counter_q;
  logic                             display_on_q;
  logic [lcd_col_pkg::DATA_W-1:0]   read_reg_q;
  logic [lcd_col_pkg::SEG_N-1:0]    data_latch_q;
  logic                             busy_q;
  logic [1:0]                       busy_cnt_q;
  logic                             init_q;
  logic [4:0]                       init_cnt_q;
  logic                             strobe_prev_q;
  logic                             phase_prev_q;
  logic                             line_prev_q;
  logic                             selected;
  logic                             strobe_fall;
  logic                             phase_rise;
  logic                             line_rise;
  logic                             line_fall;
  logic                             accept;
  logic                             do_instr;
  logic                             do_write;
  logic                             do_read;
  logic                             step_column;
  logic [lcd_col_pkg::ADDR_W-1:0]   ram_addr;
  logic [lcd_col_pkg::DATA_W-1:0]   status_word;
  logic [lcd_col_pkg::SEG_N-1:0]    row_bits;
  // Decoded strobes
  logic                             status_rd;
  logic                             busy_last;
  logic                             set_onoff;
  logic                             set_start;
  logic                             set_page;
  logic                             set_column;

  // ************************************************************
  // Bus decode
  // ************************************************************
  // All three selects must be active or the bus is ignored
  assign selected    = ~chip_select_a_n & ~chip_select_b_n & chip_select_c;
  assign strobe_fall = strobe_prev_q & ~bus_strobe;
  assign phase_rise  = phase_one & ~phase_prev_q;
  assign line_rise   = line_latch_clock & ~line_prev_q;
  assign line_fall   = ~line_latch_clock & line_prev_q;

  // A status read is answered at any time and never starts an internal operation
  assign status_rd = selected & read_not_write & ~data_not_instr;

  // Non-status operations are dropped while busy or initialising
  assign accept   = selected & strobe_fall & ~status_rd & ~busy_q & ~init_q;
  assign do_instr = accept & ~data_not_instr & ~read_not_write;
  assign do_write = accept & data_not_instr & ~read_not_write;
  assign do_read  = accept & data_not_instr & read_not_write;
  assign step_column = do_write | do_read;

  // Page above column forms the RAM address
  assign ram_addr = {page_select_q, column_counter_q};

  // ************************************************************
  // Instruction decode
  // ************************************************************
  // One strobe per instruction kind; the four codes never overlap
  assign set_onoff  = do_instr & (bus_in[7:1] == lcd_col_pkg::ONOFF_CODE);
  assign set_start  = do_instr & (bus_in[7:6] == lcd_col_pkg::START_CODE);
  assign set_page   = do_instr & (bus_in[7:3] == lcd_col_pkg::PAGE_CODE);
  assign set_column = do_instr & (bus_in[7:6] == lcd_col_pkg::COL_CODE);

  // Status byte; other bits read zero
  always_comb begin
    status_word = '0;
    status_word[lcd_col_pkg::STAT_BUSY_BIT]  = busy_q | init_q;
    status_word[lcd_col_pkg::STAT_OFF_BIT]   = ~display_on_q;
    status_word[lcd_col_pkg::STAT_RESET_BIT] = init_q;
  end

  // ************************************************************
  // Input edge samples
  // ************************************************************
  // Strobe sample; inputs are synchronous, so one stage is enough for edges
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strobe_prev_q <= 1'b0;
    end else begin
      strobe_prev_q <= bus_strobe;
    end
  end

  // Phase clock sample; a false rise after reset is harmless as busy starts clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_prev_q <= 1'b0;
    end else begin
      phase_prev_q <= phase_one;
    end
  end

  // Line clock sample; resets to the idle low level so no false edge follows reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      line_prev_q <= 1'b0;
    end else begin
      line_prev_q <= line_latch_clock;
    end
  end

  // ************************************************************
  // Initialisation window
  // ************************************************************
  // Reset bit stays set a short while after release so hosts can see it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      init_q <= 1'b1;
    end else if (init_q && init_cnt_q == 5'(lcd_col_pkg::RESET_CYCLES - 1)) begin
      init_q <= 1'b0;
    end
  end

  // Window counter; it stops once the window closes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt_q <= '0;
    end else if (init_q) begin
      init_cnt_q <= init_cnt_q + 5'h01;
    end
  end

  // ************************************************************
  // Busy timing
  // ************************************************************
  // Last counted phase-one rise of an operation
  assign busy_last = busy_q & phase_rise & (busy_cnt_q == 2'(lcd_col_pkg::BUSY_PHASES - 1));

  // Busy ends on the second phase-one rise, between one and two periods
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else if (accept) begin
      busy_q <= 1'b1;
    end else if (busy_last) begin
      busy_q <= 1'b0;
    end
  end

  // Phase-one rises seen since the operation was accepted
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_q <= '0;
    end else if (accept) begin
      busy_cnt_q <= '0;
    end else if (busy_q && phase_rise) begin
      busy_cnt_q <= busy_cnt_q + 2'h1;
    end
  end

  // ************************************************************
  // Instruction registers
  // ************************************************************
  // Display flag; reset turns the panel off, RAM is left alone
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      display_on_q <= lcd_col_pkg::DISPLAY_ON_RST;
    end else if (set_onoff) begin
      display_on_q <= bus_in[0];
    end
  end

  // Start line; only its own instruction or reset changes it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      start_line_q <= lcd_col_pkg::START_LINE_RST;
    end else if (set_start) begin
      start_line_q <= bus_in[5:0];
    end
  end

  // Page is a plain holding register with no count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      page_select_q <= '0;
    end else if (set_page) begin
      page_select_q <= bus_in[2:0];
    end
  end

  // Column counter: loaded by instruction, steps after each data access
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      column_counter_q <= '0;
    end else if (set_column) begin
      column_counter_q <= bus_in[5:0];
    end else if (step_column) begin
      column_counter_q <= column_counter_q + 6'h01;
    end
  end

  // ************************************************************
  // Display RAM
  // ************************************************************
  // Storage has no reset; contents survive display off
  always_ff @(posedge clk_sys) begin
    if (do_write) begin
      ram_q[ram_addr] <= bus_in;
    end
  end

  // Output register refills on each data read, held by other instructions
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      read_reg_q <= '0;
    end else if (do_read) begin
      read_reg_q <= ram_q[ram_addr];
    end
  end

  // ************************************************************
  // Host read path
  // ************************************************************
  // Drive the bus while a selected read strobe is high; one cycle late
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_oe_n_q <= 1'b1;
    end else begin
      bus_oe_n_q <= ~(selected & bus_strobe & read_not_write);
    end
  end

  // Output byte follows the data select, so it is ready while enable is high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_out_q <= '0;
    end else if (data_not_instr) begin
      bus_out_q <= read_reg_q;
    end else begin
      bus_out_q <= status_word;
    end
  end

  // ************************************************************
  // Refresh addressing
  // ************************************************************
  // Frame sync preset wins over counting; counter wraps naturally
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      line_counter_q <= '0;
    end else if (frame_sync) begin
      line_counter_q <= start_line_q;
    end else if (line_fall) begin
      line_counter_q <= line_counter_q + 6'h01;
    end
  end

  // Pick one bit per segment from the current line; strap sets direction
  for (genvar s = 0; s < lcd_col_pkg::SEG_N; s++) begin : g_row
    localparam logic [5:0] FWD = 6'(s);
    localparam logic [5:0] REV = 6'(lcd_col_pkg::SEG_N - 1 - s);
    logic [lcd_col_pkg::ADDR_W-1:0] addr;
    assign addr = {line_counter_q[5:3], order_select ? FWD : REV};
    assign row_bits[s] = ram_q[addr][line_counter_q[2:0]];
  end

  // Latch the row on the line clock rise; off state blanks it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_latch_q <= '0;
    end else if (line_rise) begin
      data_latch_q <= display_on_q ? row_bits : '0;
    end
  end

  // ************************************************************
  // Segment drive levels
  // ************************************************************
  // Phase and dot bit choose among four levels for every segment
  for (genvar s = 0; s < lcd_col_pkg::SEG_N; s++) begin : g_seg
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        segment_outputs_q[s*2 +: 2] <= lcd_col_pkg::LEVEL_FOUR;
      end else begin
        unique case ({ac_phase, data_latch_q[s]})
          2'b11: segment_outputs_q[s*2 +: 2] <= lcd_col_pkg::LEVEL_ONE;
          2'b10: segment_outputs_q[s*2 +: 2] <= lcd_col_pkg::LEVEL_THREE;
          2'b01: segment_outputs_q[s*2 +: 2] <= lcd_col_pkg::LEVEL_TWO;
          2'b00: segment_outputs_q[s*2 +: 2] <= lcd_col_pkg::LEVEL_FOUR;
        endcase
      end
    end
  end

endmodule // lcd_column_driver_core

// ### sim/lcd_col_checker.sv
// Port checker for the LCD column driver core
`timescale 1ns/1ps
module lcd_col_checker (
  // System
  input wire logic         clk_sys,
  input wire logic         rst_n,
  // Host bus
  input wire logic         chip_select_a_n,
  input wire logic         chip_select_b_n,
  input wire logic         chip_select_c,
  input wire logic         bus_strobe,
  input wire logic         read_not_write,
  input wire logic         data_not_instr,
  input wire logic [7:0]   bus_out_q,
  input wire logic         bus_oe_n_q,
  // Segment side
  input wire logic         ac_phase,
  input wire logic [127:0] segment_outputs_q
);
  logic [4:0]  cnt_q;
  logic [63:0] low_bits;
  logic [63:0] high_bits;
  logic        rd_req;
  logic        st_req;

  // Read requests as the device sees them
  assign rd_req = !chip_select_a_n && !chip_select_b_n && chip_select_c && bus_strobe && read_not_write;
  assign st_req = rd_req && !data_not_instr;

  // Cycles since release; saturates so a long run never wraps back into the init window
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) cnt_q <= 5'h00;
    else if (cnt_q != 5'h1f) cnt_q <= cnt_q + 5'h01;
  end

  // Split the level codes into phase half and dot half
  always_comb begin
    for (int s = 0; s < 64; s++) begin
      low_bits[s]  = segment_outputs_q[2*s];
      high_bits[s] = segment_outputs_q[2*s+1];
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_read_drives_bus: assert property (rd_req |=> !bus_oe_n_q)
    else $error("bus not driven during read");
  a_idle_releases_bus: assert property (!rd_req |=> bus_oe_n_q)
    else $error("bus driven without a selected read");
  a_status_spare_zero: assert property (st_req |=> (bus_out_q & 8'h4f) == 8'h00)
    else $error("status spare bits not zero");
  a_init_reports_reset: assert property (st_req && cnt_q < 5'd12 |=> bus_out_q[7] && bus_out_q[4])
    else $error("init window not reported");
  a_init_display_off: assert property (st_req && cnt_q < 5'd12 |=> bus_out_q[5])
    else $error("display not off after reset");
  a_init_clears_reset: assert property (st_req && cnt_q > 5'd20 |=> !bus_out_q[4])
    else $error("reset bit still set");
  a_init_dark_segs: assert property (cnt_q < 5'd15 |-> high_bits == '1)
    else $error("segments lit while display off");
  a_seg_follow_phase: assert property ((cnt_q > 5'd2) ##0 $stable(ac_phase) [*2] |-> low_bits == {64{!ac_phase}})
    else $error("segment level ignores phase");

  c_status_ready: cover property (st_req && cnt_q > 5'd20);
  c_data_read: cover property (rd_req && data_not_instr);
  c_segs_lit: cover property (high_bits != '1);
endmodule // lcd_col_checker

bind lcd_column_driver_core lcd_col_checker i_chk (.clk_sys, .rst_n, .chip_select_a_n, .chip_select_b_n,
  .chip_select_c, .bus_strobe, .read_not_write, .data_not_instr, .bus_out_q, .bus_oe_n_q, .ac_phase,
  .segment_outputs_q);

// ### sim/row_timing_model.sv
// Row driver model: phase clock, frame sync, line latch clock and AC phase
`timescale 1ns/1ps
module row_timing_model #(
  parameter int PHASE_HALF = 4
) (
  input  wire logic clk_sys,
  output logic      phase_one,
  output logic      frame_sync,
  output logic      line_latch_clock,
  output logic      ac_phase
);
  int ph_cnt = 0;

  initial begin
    phase_one = 1'b0;
    frame_sync = 1'b0;
    line_latch_clock = 1'b0;
    ac_phase = 1'b0;
  end

  // Free running phase clock; a larger PHASE_HALF makes a slow partner and longer busy
  always @(posedge clk_sys) begin
    ph_cnt <= (ph_cnt == PHASE_HALF - 1) ? 0 : ph_cnt + 1;
    if (ph_cnt == PHASE_HALF - 1) phase_one <= !phase_one;
  end

  // One display line; the line clock stands low between lines
  task automatic line_pulse(input logic fs, input logic ac);
    @(posedge clk_sys);
    frame_sync <= fs;
    ac_phase <= ac;
    repeat (2) @(posedge clk_sys);
    frame_sync <= 1'b0;
    line_latch_clock <= 1'b1;
    repeat (4) @(posedge clk_sys);
    line_latch_clock <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
endmodule // row_timing_model

// ### sim/lcd_column_driver_core_bench.sv
// Self-checking bench for the LCD column driver core
`timescale 1ns/1ps
module lcd_column_driver_core_bench;
  logic         clk_sys, rst_n, cs_a_n, cs_b_n, cs_c, strobe, rnw, dni, order_select;
  logic [7:0]   bus_in, bus_out_q, rd, out_m;
  logic         bus_oe_n_q, phase_one, frame_sync, line_latch_clock, ac_phase, on_m;
  logic [127:0] segment_outputs_q;
  logic [7:0]   ram_m [512];
  int           n_mismatch, checks_done, seed, pg, col;

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  lcd_column_driver_core i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .chip_select_a_n(cs_a_n),
    .chip_select_b_n(cs_b_n), .chip_select_c(cs_c), .bus_strobe(strobe), .read_not_write(rnw),
    .data_not_instr(dni), .bus_in(bus_in), .bus_out_q(bus_out_q), .bus_oe_n_q(bus_oe_n_q),
    .order_select(order_select), .phase_one(phase_one), .frame_sync(frame_sync),
    .line_latch_clock(line_latch_clock), .ac_phase(ac_phase), .segment_outputs_q(segment_outputs_q));

  row_timing_model #(.PHASE_HALF(4)) i_row (.clk_sys(clk_sys), .phase_one(phase_one),
    .frame_sync(frame_sync), .line_latch_clock(line_latch_clock), .ac_phase(ac_phase));

  // ********
  // Helpers
  // ********
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One strobe cycle; read data taken while the strobe is still high
  task automatic bus(input logic rw, input logic di, input logic ok, input logic [7:0] d);
    @(posedge clk_sys);
    cs_a_n <= 1'b0;
    cs_b_n <= 1'b0;
    cs_c <= ok;
    strobe <= 1'b1;
    rnw <= rw;
    dni <= di;
    bus_in <= d;
    repeat (2) @(posedge clk_sys);
    #1 rd = bus_out_q;
    @(posedge clk_sys);
    strobe <= 1'b0;
    @(posedge clk_sys);
    cs_a_n <= 1'b1;
    cs_b_n <= 1'b1;
    cs_c <= 1'b0;
    bus_in <= ~d;
  endtask

  // Poll status until busy clears, bounded so a stuck flag cannot hang the run
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      bus(1'b1, 1'b0, 1'b1, 8'h00);
      n++;
    end while (rd[7] && n < 100);
    check(128'(rd[7]), 128'h0);
  endtask

  task automatic cmd(input logic [7:0] c);
    bus(1'b0, 1'b0, 1'b1, c);
    wait_ready();
    if (c[7:1] == 7'h1f) on_m = c[0];
    else if (c[7:3] == 5'h17) pg = c[2:0];
    else if (c[7:6] == 2'h1) col = c[5:0];
  endtask

  task automatic wr(input logic [7:0] d);
    bus(1'b0, 1'b1, 1'b1, d);
    wait_ready();
    ram_m[pg*64+col] = d;
    col = (col + 1) % 64;
  endtask

  // Data read hands back the previous fetch, so the model lags one access
  task automatic rdd(input bit chk);
    bus(1'b1, 1'b1, 1'b1, 8'h00);
    if (chk) check(128'(rd), 128'(out_m));
    wait_ready();
    out_m = ram_m[pg*64+col];
    col = (col + 1) % 64;
  endtask

  task automatic fill(input logic [2:0] p);
    cmd(8'hb8 | 8'(p));
    cmd(8'h40);
    repeat (64) wr(8'($random(seed)));
  endtask

  function automatic logic [127:0] seg_exp(input int ln, input logic ac);
    logic [127:0] r;
    logic [7:0]   b;
    for (int s = 0; s < 64; s++) begin
      b = ram_m[(ln / 8) * 64 + (order_select ? s : 63 - s)];
      r[2*s +: 2] = {!(on_m && b[ln % 8]), !ac};
    end
    return r;
  endfunction

  task automatic line(input logic fs, input logic ac, input int ln);
    i_row.line_pulse(fs, ac);
    check(segment_outputs_q, seg_exp(ln, ac));
  endtask

  task automatic do_reset(input logic ord);
    rst_n <= 1'b0;
    order_select <= ord;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    on_m = 1'b0;
    pg = 0;
    col = 0;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ********
  // Sequence
  // ********
  initial begin
    seed = 32'hdd4b;
    n_mismatch = 0;
    checks_done = 0;
    rst_n = 1'b0;
    {cs_a_n, cs_b_n, cs_c, strobe, rnw, dni} = 6'h30;
    bus_in = 8'h00;
    order_select = 1'b1;
    do_reset(1'b1);
    bus(1'b1, 1'b0, 1'b1, 8'h00);
    check(128'(rd), 128'hb0);
    wait_ready();
    check(128'(rd), 128'h20);
    $display("test init done");
    // Column wrap inside page 2, a write refused while busy, an unselected write
    cmd(8'hba);
    cmd(8'h7c);
    repeat (8) wr(8'($random(seed)));
    bus(1'b0, 1'b1, 1'b1, 8'h11);
    bus(1'b0, 1'b1, 1'b1, 8'h22);
    wait_ready();
    ram_m[pg*64+col] = 8'h11;
    col = col + 1;
    bus(1'b0, 1'b1, 1'b0, 8'h33);
    wr(8'h44);
    cmd(8'h7c);
    rdd(1'b0);
    repeat (10) rdd(1'b1);
    $display("test addressing done");
    // Start line 63 wraps into line 0; display off blanks and on restores
    fill(3'h0);
    fill(3'h7);
    cmd(8'hff);
    cmd(8'h3f);
    check(128'(rd), 128'h00);
    line(1'b1, 1'b0, 63);
    line(1'b0, 1'b1, 0);
    line(1'b0, 1'b0, 1);
    cmd(8'h3e);
    line(1'b0, 1'b1, 2);
    cmd(8'h3f);
    line(1'b1, 1'b1, 63);
    $display("test display done");
    // Second reset mid-run with the reversed segment order
    do_reset(1'b0);
    wait_ready();
    check(128'(rd), 128'h20);
    fill(3'h0);
    cmd(8'h3f);
    line(1'b1, 1'b1, 0);
    $display("test reset order done");
    tally_and_finish();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #500000;
    n_mismatch++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule // lcd_column_driver_core_bench
